// ---- core/sfsr_bank.v ----
// Purpose: three status/config bytes of a serial NOR flash behind its serial link
// Assumes: link mode 0, sampled by sys_clk (link clock at most sys_clk/8); rstn is the power cycle
// Notes: array operations are modelled only as busy timers
// What this block does
// - status bit 0 reads 1 while status write, program or erase runs.
// - bit 1 mirrors write latch; when clear, status write, program, erase refused.
// - five area-guard bits 6..2 written only by status write, with invert select region.
// - page program, sector and block erase into guarded region are rejected.
// - area-guard bits writable only outside hardware-protected mode.
// - chip erase only if guard 2..0 all 0 with invert 0, or all 1 with invert 1.
// - guard mode 00: status writable whenever latch set, pin ignored.
// - guard mode 01 with guard pin low and quad-enable 0: status registers locked.
// - guard mode 01 with guard pin high: writable once latch set.
// - guard mode 10: no status writes until power cycle, which restores mode 00.
// - guard mode 11: no status writes until power cycle, same as mode 10.
// - quad-enable bit 9 defaults 0; when 1 guard and pause pins become lanes.
// - lock bits 13..11 default 0, set individually, cleared only by power cycle.
// - invert bit 14 defaults 0 and inverts the guarded region.
// - suspend sets bit 15 for paused erase, bit 10 for paused program.
// - resume, software reset and power cycle clear both suspend flags.
// - wait bit 16 picks dummy cycles: dual 4/8, quad 6/10.
// - drive field bits 22..21: 00 100%, 01 75% default, 10 50%, 11 25%.
// - latch clears on power-up, reset, disarm, and end of write, program, erase.
// - guard pin low in hardware mode protects area-guard and guard-mode bits while quad-enable is 0.
// - pause pin works only with quad-enable 0; otherwise it is a data line.
`timescale 1ns/1ps
`include "sfsr_defs.vh"
module sfsr_bank #(
	parameter [23:0] SRW_CYC   = `SFSR_SRW_CYC,
	parameter [23:0] PROG_CYC  = `SFSR_PROG_CYC,
	parameter [23:0] ERASE_CYC = `SFSR_ERASE_CYC
) (
	input  wire       sys_clk,
	input  wire       rstn,
	input  wire       sck,
	input  wire       cs_n,
	input  wire       si,
	input  wire       guard_n,
	input  wire       pause_n,
	output reg        so_out,
	output reg        so_oe_n,
	output reg        write_busy_flag,
	output reg        four_lane_enable,
	output reg  [2:0] secure_lock,
	output reg  [1:0] drive_level,
	output reg  [3:0] dual_dummy_cycles,
	output reg  [3:0] quad_dummy_cycles
);
	localparam [1:0] OP_NONE  = 2'h0;
	localparam [1:0] OP_SRW   = 2'h1;
	localparam [1:0] OP_PROG  = 2'h2;
	localparam [1:0] OP_ERASE = 2'h3;

	wire [4:0] pins_s;
	wire       sck_s    = pins_s[0];
	wire       cs_n_s   = pins_s[1];
	wire       si_s     = pins_s[2];
	wire       guard_n_s = pins_s[3];
	wire       pause_n_s = pins_s[4];

	sfsr_sync #(.W(5), .RST_VAL(5'h1a)) u_sync (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.d_in    ({pause_n, guard_n, si, cs_n, sck}),
		.q_out   (pins_s)
	);

	reg        sck_d_reg;
	reg        cs_d_reg;
	reg  [7:0] rx_reg;
	reg  [2:0] bit_cnt_reg;
	reg  [2:0] byte_cnt_reg;
	reg  [7:0] cmd_reg;
	reg  [7:0] data_reg;
	reg [23:0] addr_reg;
	reg  [7:0] tx_reg;
	reg        rst_armed_reg;
	reg        latch_reg;
	reg  [4:0] guard_reg;
	reg  [1:0] mode_reg;
	reg        quad_reg;
	reg  [2:0] lock_reg;
	reg        invert_reg;
	reg        erase_pause_reg;
	reg        prog_pause_reg;
	reg        wait_reg;
	reg  [1:0] drv_reg;
	reg  [1:0] op_reg;
	reg [23:0] op_cnt_reg;

	// pause pin is a data lane once four lanes are on
	wire hold_act = ~quad_reg & ~pause_n_s;
	wire sck_rise = sck_s & ~sck_d_reg & ~cs_n_s & ~hold_act;
	wire sck_fall = ~sck_s & sck_d_reg & ~cs_n_s & ~hold_act;
	wire cs_rise  = cs_n_s & ~cs_d_reg;
	wire [7:0] rx_next = {rx_reg[6:0], si_s};
	wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);
	wire paused = erase_pause_reg | prog_pause_reg;
	wire busy = (op_reg != OP_NONE) & ~paused;
	// guard pin loses its function in quad mode, so it reads as released
	wire guard_hi = guard_n_s | quad_reg;

	wire [7:0] sr1 = {mode_reg[0], guard_reg, latch_reg, busy};
	wire [7:0] sr2 = {erase_pause_reg, invert_reg, lock_reg, prog_pause_reg, quad_reg, mode_reg[1]};
	wire [7:0] sr3 = {1'b0, drv_reg, 4'h0, wait_reg};

	// mode 00 free, 01 follows the pin, 10 and 11 locked
	wire sr_unlocked = (mode_reg == 2'h0) | ((mode_reg == 2'h1) & guard_hi);
	wire can_modify  = latch_reg & ~busy & ~paused;
	wire chip_ok = ((guard_reg[2:0] == 3'h0) & ~invert_reg) | ((guard_reg[2:0] == 3'h7) & invert_reg);

	function in_guard;
		input [22:0] a;
		input  [4:0] bp;
		input        inv;
		reg          hit;
		reg    [7:0] nblk;
		reg   [11:0] nsec;
		reg    [1:0] sh;
		begin
			nblk = 8'h01 << bp[2:0];
			sh   = bp[1:0] - 2'h1;
			nsec = bp[2] ? 12'h008 : (12'h001 << sh);
			if (bp[2:0] == 3'h0)
				hit = 1'b0;
			else if (bp[2:0] == 3'h7)
				hit = 1'b1;
			else if (!bp[4])
				hit = bp[3] ? ({1'b0, a[22:16]} < nblk) : ({1'b0, a[22:16]} >= (8'h80 - nblk));
			else
				hit = bp[3] ? ({1'b0, a[22:12]} < nsec) : ({1'b0, a[22:12]} >= (12'h800 - nsec));
			in_guard = hit ^ inv;
		end
	endfunction

	wire addr_guarded = in_guard(addr_reg[22:0], guard_reg, invert_reg);
	wire aligned = (bit_cnt_reg == 3'h0);
	wire is_read = (cmd_reg == `SFSR_CMD_RD1) | (cmd_reg == `SFSR_CMD_RD2) | (cmd_reg == `SFSR_CMD_RD3);
	wire is_erase = (cmd_reg == `SFSR_CMD_SECTOR) | (cmd_reg == `SFSR_CMD_BLK32) | (cmd_reg == `SFSR_CMD_BLK64);
	wire is_chip = (cmd_reg == `SFSR_CMD_CHIP_A) | (cmd_reg == `SFSR_CMD_CHIP_B);
	wire exec = cs_rise & aligned & (byte_cnt_reg != 3'h0);
	wire op_done = busy & (op_cnt_reg == 24'h000001);

	// frame capture
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sck_d_reg    <= 1'b0;
			cs_d_reg     <= 1'b1;
			rx_reg       <= 8'h00;
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
			cmd_reg      <= 8'h00;
			data_reg     <= 8'h00;
			addr_reg     <= 24'h000000;
			tx_reg       <= 8'h00;
			so_out       <= 1'b0;
			so_oe_n      <= 1'b1;
		end else begin
			sck_d_reg <= sck_s;
			cs_d_reg  <= cs_n_s;
			so_oe_n   <= ~(~cs_n_s & ~hold_act & is_read & (byte_cnt_reg != 3'h0));
			if (cs_n_s) begin
				bit_cnt_reg  <= 3'h0;
				byte_cnt_reg <= 3'h0;
			end else if (sck_rise) begin
				rx_reg      <= rx_next;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (byte_done) begin
					if (byte_cnt_reg != 3'h7)
						byte_cnt_reg <= byte_cnt_reg + 3'h1;
					if (byte_cnt_reg == 3'h0)
						cmd_reg <= rx_next;
					if (byte_cnt_reg == 3'h1)
						data_reg <= rx_next;
					if ((byte_cnt_reg != 3'h0) && (byte_cnt_reg < 3'h4))
						addr_reg <= {addr_reg[15:0], rx_next};
					// status reads repeat the same byte while clocked
					if (byte_cnt_reg == 3'h0)
						tx_reg <= (rx_next == `SFSR_CMD_RD2) ? sr2 : ((rx_next == `SFSR_CMD_RD3) ? sr3 : sr1);
					else
						tx_reg <= (cmd_reg == `SFSR_CMD_RD2) ? sr2 : ((cmd_reg == `SFSR_CMD_RD3) ? sr3 : sr1);
				end
			end else if (sck_fall && is_read && (byte_cnt_reg != 3'h0)) begin
				so_out <= tx_reg[7];
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	// status bits and operation timer
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			latch_reg       <= 1'b0;
			guard_reg       <= `SFSR_RST_GUARD;
			mode_reg        <= `SFSR_RST_MODE;
			quad_reg        <= 1'b0;
			lock_reg        <= `SFSR_RST_LOCK;
			invert_reg      <= 1'b0;
			erase_pause_reg <= 1'b0;
			prog_pause_reg  <= 1'b0;
			wait_reg        <= 1'b0;
			drv_reg         <= `SFSR_RST_DRV;
			op_reg          <= OP_NONE;
			op_cnt_reg      <= 24'h000000;
			rst_armed_reg   <= 1'b0;
		end else begin
			if (busy)
				op_cnt_reg <= op_cnt_reg - 24'h000001;
			if (op_done) begin
				op_reg    <= OP_NONE;
				latch_reg <= 1'b0;
			end
			if (exec) begin
				rst_armed_reg <= (cmd_reg == `SFSR_CMD_RST_EN) & (byte_cnt_reg == 3'h1);
				case (cmd_reg)
				`SFSR_CMD_ARM: begin
					if (!busy && byte_cnt_reg == 3'h1)
						latch_reg <= 1'b1;
				end
				`SFSR_CMD_DISARM: begin
					if (!busy && byte_cnt_reg == 3'h1)
						latch_reg <= 1'b0;
				end
				`SFSR_CMD_WR1, `SFSR_CMD_WR2, `SFSR_CMD_WR3: begin
					// busy, latch and suspend flags are never taken from the data byte
					if (can_modify && sr_unlocked && byte_cnt_reg == 3'h2) begin
						if (cmd_reg == `SFSR_CMD_WR1) begin
							guard_reg   <= data_reg[`SFSR_S1_GUARD_HI:`SFSR_S1_GUARD_LO];
							mode_reg[0] <= data_reg[`SFSR_S1_MODE_LOW];
						end else if (cmd_reg == `SFSR_CMD_WR2) begin
							mode_reg[1] <= data_reg[`SFSR_S2_MODE_HIGH];
							quad_reg    <= data_reg[`SFSR_S2_QUAD];
							lock_reg    <= lock_reg | data_reg[`SFSR_S2_LOCK_HI:`SFSR_S2_LOCK_LO];
							invert_reg  <= data_reg[`SFSR_S2_INVERT];
						end else begin
							wait_reg <= data_reg[`SFSR_S3_WAIT];
							drv_reg  <= data_reg[`SFSR_S3_DRV_HI:`SFSR_S3_DRV_LO];
						end
						op_reg     <= OP_SRW;
						op_cnt_reg <= SRW_CYC;
					end
				end
				`SFSR_CMD_PAGE: begin
					if (can_modify && !addr_guarded && byte_cnt_reg >= 3'h5) begin
						op_reg     <= OP_PROG;
						op_cnt_reg <= PROG_CYC;
					end
				end
				`SFSR_CMD_PAUSE: begin
					if (busy && op_reg == OP_ERASE)
						erase_pause_reg <= 1'b1;
					if (busy && op_reg == OP_PROG)
						prog_pause_reg <= 1'b1;
				end
				`SFSR_CMD_RESUME: begin
					erase_pause_reg <= 1'b0;
					prog_pause_reg  <= 1'b0;
				end
				`SFSR_CMD_RST: begin
					if (rst_armed_reg && byte_cnt_reg == 3'h1) begin
						latch_reg       <= 1'b0;
						erase_pause_reg <= 1'b0;
						prog_pause_reg  <= 1'b0;
						op_reg          <= OP_NONE;
					end
				end
				default: begin
					if (is_erase && can_modify && !addr_guarded && byte_cnt_reg == 3'h4) begin
						op_reg     <= OP_ERASE;
						op_cnt_reg <= ERASE_CYC;
					end
					if (is_chip && can_modify && chip_ok && byte_cnt_reg == 3'h1) begin
						op_reg     <= OP_ERASE;
						op_cnt_reg <= ERASE_CYC;
					end
				end
				endcase
			end
		end
	end

	// registered copies of busy and the configuration for the rest of the chip
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			write_busy_flag   <= 1'b0;
			four_lane_enable  <= 1'b0;
			secure_lock       <= `SFSR_RST_LOCK;
			drive_level       <= `SFSR_RST_DRV;
			dual_dummy_cycles <= `SFSR_DUAL_DUMMY_0;
			quad_dummy_cycles <= `SFSR_QUAD_DUMMY_0;
		end else begin
			write_busy_flag   <= busy;
			four_lane_enable  <= quad_reg;
			secure_lock       <= lock_reg;
			drive_level       <= drv_reg;
			dual_dummy_cycles <= wait_reg ? `SFSR_DUAL_DUMMY_1 : `SFSR_DUAL_DUMMY_0;
			quad_dummy_cycles <= wait_reg ? `SFSR_QUAD_DUMMY_1 : `SFSR_QUAD_DUMMY_0;
		end
	end
endmodule

// ---- core/sfsr_defs.vh ----
// Purpose: constants for the serial flash status register bank
// Assumes: included by bare name; definitions only
// Notes: times are in microseconds; cycle counts derive from the clock rate
`ifndef SFSR_DEFS_VH
`define SFSR_DEFS_VH

`define SFSR_CLK_MHZ        20
`define SFSR_SRW_US         5
`define SFSR_PROG_US        600
`define SFSR_ERASE_US       45000
`define SFSR_SRW_CYC        24'h000064
`define SFSR_PROG_CYC       24'h002ee0
`define SFSR_ERASE_CYC      24'h0dbba0

// command codes
`define SFSR_CMD_ARM        8'h06
`define SFSR_CMD_DISARM     8'h04
`define SFSR_CMD_RD1        8'h05
`define SFSR_CMD_RD2        8'h35
`define SFSR_CMD_RD3        8'h15
`define SFSR_CMD_WR1        8'h01
`define SFSR_CMD_WR2        8'h31
`define SFSR_CMD_WR3        8'h11
`define SFSR_CMD_PAGE       8'h02
`define SFSR_CMD_SECTOR     8'h20
`define SFSR_CMD_BLK32      8'h52
`define SFSR_CMD_BLK64      8'hd8
`define SFSR_CMD_CHIP_A     8'h60
`define SFSR_CMD_CHIP_B     8'hc7
`define SFSR_CMD_PAUSE      8'h75
`define SFSR_CMD_RESUME     8'h7a
`define SFSR_CMD_RST_EN     8'h66
`define SFSR_CMD_RST        8'h99

// field positions inside each status byte
`define SFSR_S1_BUSY        0
`define SFSR_S1_LATCH       1
`define SFSR_S1_GUARD_LO    2
`define SFSR_S1_GUARD_HI    6
`define SFSR_S1_MODE_LOW    7
`define SFSR_S2_MODE_HIGH   0
`define SFSR_S2_QUAD        1
`define SFSR_S2_PROG_PAUSE  2
`define SFSR_S2_LOCK_LO     3
`define SFSR_S2_LOCK_HI     5
`define SFSR_S2_INVERT      6
`define SFSR_S2_ERASE_PAUSE 7
`define SFSR_S3_WAIT        0
`define SFSR_S3_DRV_LO      5
`define SFSR_S3_DRV_HI      6

// reset values
`define SFSR_RST_GUARD      5'h00
`define SFSR_RST_MODE       2'h0
`define SFSR_RST_DRV        2'h1
`define SFSR_RST_LOCK       3'h0

// dummy cycle counts
`define SFSR_DUAL_DUMMY_0   4'h4
`define SFSR_DUAL_DUMMY_1   4'h8
`define SFSR_QUAD_DUMMY_0   4'h6
`define SFSR_QUAD_DUMMY_1   4'ha

`endif

// ---- core/sfsr_sync.v ----
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: one clock; asynchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sfsr_sync #(
	parameter       W     = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input  wire         sys_clk,
	input  wire         rstn,
	input  wire [W-1:0] d_in,
	output reg  [W-1:0] q_out
);
	reg [W-1:0] meta_reg;

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RST_VAL;
			q_out    <= RST_VAL;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule

// ---- tb/sfsr_host.sv ----
// Purpose: serial host that frames mode-0 commands for the status bank
// Assumes: link clock 400 ns; every pin moves on a sys_clk fall
// Notes: si flips when deselected so stale data never looks valid
`timescale 1ns/1ps
module sfsr_host (
	input  wire sys_clk,
	input  wire so_out,
	input  wire so_oe_n,
	output reg  sck,
	output reg  cs_n,
	output reg  si
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task hw(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	// msb first; only whole bytes are ever sent, so no frame is misaligned
	task xfer(input integer nb, input [63:0] tx, output [7:0] rx);
		integer i;
		begin
			rx = 8'h00;
			cs_n = 1'b0;
			hw(4);
			for (i = 0; i < nb * 8; i = i + 1) begin
				si = tx[63-i];
				hw(4);
				sck = 1'b1;
				// released line shows the inverse of the last bit
				rx = {rx[6:0], so_oe_n ? ~so_out : so_out};
				hw(4);
				sck = 1'b0;
			end
			hw(4);
			cs_n = 1'b1;
			si = ~si;
			hw(12);
		end
	endtask
endmodule

// ---- tb/sfsr_bank_chk.sv ----
// Purpose: port-level checks on the status bank
// Assumes: one clock domain, active-low asynchronous reset
// Notes: lock and drive changes must meet a busy start, quad changes a frame end, dummy changes both
`timescale 1ns/1ps
module sfsr_bank_chk (
	input wire       sys_clk,
	input wire       rstn,
	input wire       cs_n,
	input wire       write_busy_flag,
	input wire       four_lane_enable,
	input wire [2:0] secure_lock,
	input wire [1:0] drive_level,
	input wire [3:0] dual_dummy_cycles,
	input wire [3:0] quad_dummy_cycles
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_busy_min;
		$rose(write_busy_flag) |-> write_busy_flag [*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy pulse too short");
	property p_busy_start;
		$rose(write_busy_flag) |-> cs_n && $past(cs_n);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy rose inside a frame");
	property p_lock_sticky;
		($past(secure_lock) & ~secure_lock) == 3'h0;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
	property p_lock_busy;
		$changed(secure_lock) |-> ##[0:1] write_busy_flag;
	endproperty
	a_lock_busy: assert property (p_lock_busy) else $error("lock changed without a write");
	property p_quad_wr;
		$changed(four_lane_enable) |-> cs_n && $past(cs_n);
	endproperty
	a_quad_wr: assert property (p_quad_wr) else $error("quad enable changed mid frame");
	property p_drive_wr;
		$changed(drive_level) |-> ##[0:1] write_busy_flag;
	endproperty
	a_drive_wr: assert property (p_drive_wr) else $error("drive changed without a write");
	property p_dummy_pair;
		dual_dummy_cycles == 4'h4 ? quad_dummy_cycles == 4'h6 : dual_dummy_cycles == 4'h8 && quad_dummy_cycles == 4'ha;
	endproperty
	a_dummy_pair: assert property (p_dummy_pair) else $error("dummy counts disagree");
	property p_dummy_wr;
		$changed(dual_dummy_cycles) |-> cs_n ##[0:1] write_busy_flag;
	endproperty
	a_dummy_wr: assert property (p_dummy_wr) else $error("dummy changed without a write");
endmodule
bind sfsr_bank sfsr_bank_chk u_chk (
	.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n), .write_busy_flag(write_busy_flag),
	.four_lane_enable(four_lane_enable), .secure_lock(secure_lock), .drive_level(drive_level),
	.dual_dummy_cycles(dual_dummy_cycles), .quad_dummy_cycles(quad_dummy_cycles)
);

// ---- tb/sfsr_bank_tb_top.sv ----
// Purpose: self-checking bench for the status bank
// Assumes: a short erase timer so a run stays small
// Notes: hold exercised with four lanes off and on; program timer left at default
`timescale 1ns/1ps
module sfsr_bank_tb_top;
	reg        sys_clk;
	reg        rstn;
	reg        guard_n;
	reg        pause_n;
	reg  [7:0] r;
	integer    miscompares;
	integer    n_checks;
	wire       sck, cs_n, si, so_out, so_oe_n, write_busy_flag, four_lane_enable;
	wire [2:0] secure_lock;
	wire [1:0] drive_level;
	wire [3:0] dual_dummy_cycles, quad_dummy_cycles;
	sfsr_bank #(.ERASE_CYC(24'h0007d0)) dut (
		.sys_clk(sys_clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .guard_n(guard_n),
		.pause_n(pause_n), .so_out(so_out), .so_oe_n(so_oe_n), .write_busy_flag(write_busy_flag),
		.four_lane_enable(four_lane_enable), .secure_lock(secure_lock), .drive_level(drive_level),
		.dual_dummy_cycles(dual_dummy_cycles), .quad_dummy_cycles(quad_dummy_cycles));
	sfsr_host host (.sys_clk(sys_clk), .so_out(so_out), .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n), .si(si));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task chk(input [7:0] exp, input [7:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
			end
		end
	endtask
	task cmd(input [7:0] c);
		host.xfer(1, {c, 56'h0}, r);
	endtask
	task rd(input [7:0] c, input [7:0] exp);
		begin
			host.xfer(2, {c, 56'h0}, r);
			chk(exp, r);
		end
	endtask
	// polls busy; a refused write costs one poll only
	task idle;
		integer k;
		begin
			r = 8'h01;
			for (k = 0; k < 40 && r[0] !== 1'b0; k = k + 1)
				host.xfer(2, {8'h05, 56'h0}, r);
			chk(8'h00, {7'h0, r[0]});
		end
	endtask
	task wr(input [7:0] c, input [7:0] d);
		begin
			cmd(8'h06);
			host.xfer(2, {c, d, 48'h0}, r);
			idle;
		end
	endtask
	task results;
		begin
			if (miscompares == 0 && n_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial begin
		#4000000;
		miscompares = miscompares + 1;
		results;
	end
	initial begin
		rstn = 1'b0;
		guard_n = 1'b0;
		pause_n = 1'b1;
		miscompares = 0;
		n_checks = 0;
		host.hw(20);
		rstn = 1'b1;
		host.hw(6);
		rd(8'h35, 8'h00);
		rd(8'h15, 8'h20);
		chk(8'h46, {dual_dummy_cycles, quad_dummy_cycles});
		host.xfer(2, {8'h01, 8'h1c, 48'h0}, r);
		rd(8'h05, 8'h00);
		cmd(8'h06);
		rd(8'h05, 8'h02);
		cmd(8'h04);
		rd(8'h05, 8'h00);
		cmd(8'h06);
		host.xfer(2, {8'h01, 8'h1f, 48'h0}, r);
		rd(8'h05, 8'h1f);
		idle;
		rd(8'h05, 8'h1c);
		cmd(8'h06);
		cmd(8'h60);
		rd(8'h05, 8'h1e);
		host.xfer(5, {8'h02, 24'h0, 8'ha5, 24'h0}, r);
		rd(8'h05, 8'h1e);
		host.xfer(4, {8'h20, 24'h000000, 32'h0}, r);
		rd(8'h05, 8'h1e);
		host.xfer(4, {8'h52, 24'h400000, 32'h0}, r);
		rd(8'h05, 8'h1e);
		host.xfer(4, {8'hd8, 24'h7f0000, 32'h0}, r);
		rd(8'h05, 8'h1e);
		wr(8'h31, 8'h40);
		rd(8'h35, 8'h40);
		cmd(8'h06);
		cmd(8'hc7);
		rd(8'h05, 8'h1f);
		cmd(8'h75);
		rd(8'h35, 8'hc0);
		cmd(8'h7a);
		rd(8'h35, 8'h40);
		idle;
		rd(8'h05, 8'h1c);
		cmd(8'h06);
		host.xfer(5, {8'h02, 24'h0, 8'ha5, 24'h0}, r);
		cmd(8'h75);
		rd(8'h35, 8'h44);
		cmd(8'h66);
		cmd(8'h99);
		rd(8'h35, 8'h40);
		rd(8'h05, 8'h1c);
		wr(8'h01, 8'h9c);
		wr(8'h01, 8'h00);
		rd(8'h05, 8'h9e);
		guard_n = 1'b1;
		wr(8'h01, 8'h80);
		rd(8'h05, 8'h80);
		wr(8'h31, 8'h4a);
		chk(8'h01, {7'h0, four_lane_enable});
		pause_n = 1'b0;
		cmd(8'h06);
		rd(8'h05, 8'h82);
		pause_n = 1'b1;
		guard_n = 1'b0;
		wr(8'h31, 8'h40);
		rd(8'h35, 8'h48);
		pause_n = 1'b0;
		cmd(8'h06);
		pause_n = 1'b1;
		rd(8'h05, 8'h80);
		guard_n = 1'b1;
		wr(8'h11, 8'h41);
		rd(8'h15, 8'h41);
		chk(8'h8a, {dual_dummy_cycles, quad_dummy_cycles});
		chk(8'h11, {3'h0, drive_level, secure_lock});
		wr(8'h01, 8'h00);
		wr(8'h31, 8'h49);
		wr(8'h11, 8'h20);
		rd(8'h15, 8'h41);
		rstn = 1'b0;
		host.hw(20);
		rstn = 1'b1;
		host.hw(6);
		rd(8'h35, 8'h00);
		wr(8'h01, 8'h80);
		wr(8'h31, 8'h01);
		wr(8'h11, 8'h00);
		rd(8'h15, 8'h20);
		results;
	end
endmodule
